// >>> common/fifo_port_pkg.sv
package fifo_port_pkg;

	// Storage geometry
	localparam int DEPTH_LOG2 = 16;
	localparam int WORD_W = 36;

	// Values forced while master reset is low
	localparam logic [35:0] RESET_DATA_OUT = 36'h0;
	localparam logic RESET_ALMOST_EMPTY_N = 1'b0;
	localparam logic RESET_ALMOST_FULL_N = 1'b1;
	localparam logic RESET_HALF_FULL_N = 1'b1;

	// Default offset pairs picked by {offset load, select1, select0}
	localparam logic [15:0] DEFAULT_OFFSET [8] = '{
		16'h007f, 16'h03ff, 16'h000f, 16'h001f,
		16'h007f, 16'h03ff, 16'h000f, 16'h001f
	};

	typedef enum logic [1:0] {
		WIDTH_X36 = 2'b00,
		WIDTH_X18 = 2'b01,
		WIDTH_X9 = 2'b10
	} port_width_t;

	// Every pin that crosses into the system clock
	typedef struct packed {
		logic write_clock;
		logic read_clock;
		logic master_reset_n;
		logic write_enable_n;
		logic read_enable_n;
		logic serial_load_enable_n;
		logic offset_load_n;
		logic output_enable_n;
		logic serial_in;
		logic [1:0] offset_select;
		logic bus_match_select;
		logic input_width_select;
		logic output_width_select;
		logic endian_select;
		logic async_write_select_n;
		logic async_read_select_n;
		logic [35:0] data_in_bus;
	} pins_t;

	// Settings caught during master reset
	typedef struct packed {
		logic fall_through_mode;
		logic serial_prog;
		port_width_t in_width;
		port_width_t out_width;
		logic little_endian;
		logic async_write;
		logic async_read;
	} cfg_t;

	// Index of the last sub-word of a long word
	function automatic logic [1:0] width_last(port_width_t w);
		case (w)
			WIDTH_X18: return 2'h1;
			WIDTH_X9: return 2'h3;
			default: return 2'h0;
		endcase
	endfunction

	// Slot of the n-th sub-word inside the long word
	function automatic logic [1:0] part_pos(logic [1:0] part, port_width_t w, logic little);
		return little ? part : 2'(width_last(w) - part);
	endfunction

	// Insert a narrow input into its slot
	function automatic logic [35:0] place(logic [35:0] word, logic [35:0] data,
		logic [1:0] pos, port_width_t w);
		logic [35:0] r;
		r = word;
		case (w)
			WIDTH_X18: r[pos[0]*18 +: 18] = data[17:0];
			WIDTH_X9: r[pos*9 +: 9] = data[8:0];
			default: r = data;
		endcase
		return r;
	endfunction

	// Extract one slot into the low bits
	function automatic logic [35:0] pick(logic [35:0] word, logic [1:0] pos, port_width_t w);
		case (w)
			WIDTH_X18: return {18'h0, word[pos[0]*18 +: 18]};
			WIDTH_X9: return {27'h0, word[pos*9 +: 9]};
			default: return word;
		endcase
	endfunction

endpackage

// >>> sim/dual_clock_bus_matching_fifo_ports_bench.sv
`timescale 1ns/1ps
module dual_clock_bus_matching_fifo_ports_bench;
	import fifo_port_pkg::*;
	logic clk_sys_i, rst_b_i, wclk, rclk, wen_n, ren_n;
	logic oe, ef, ff, aef, aff, hff;
	logic [35:0] din, dout;
	pins_t pin;
	logic [35:0] exp_q[$];
	logic [35:0] w[17];
	int mismatches, n_checks, cyc;

	fifo_port_partner partner (.write_clock_o(wclk), .read_clock_o(rclk),
		.write_enable_n_o(wen_n), .read_enable_n_o(ren_n), .data_in_bus_o(din));

	fifo_port_core #(.PTR_W(4)) uut (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.write_clock_i(wclk), .read_clock_i(rclk),
		.master_reset_n_i(pin.master_reset_n),
		.write_enable_n_i(wen_n), .read_enable_n_i(ren_n),
		.serial_load_enable_n_i(pin.serial_load_enable_n),
		.offset_load_n_i(pin.offset_load_n),
		.output_enable_n_i(pin.output_enable_n),
		.fallthrough_select_serial_in_i(pin.serial_in),
		.default_offset_select0_i(pin.offset_select[0]),
		.default_offset_select1_i(pin.offset_select[1]),
		.bus_match_select_i(pin.bus_match_select),
		.input_width_select_i(pin.input_width_select),
		.output_width_select_i(pin.output_width_select),
		.endian_select_i(pin.endian_select),
		.async_write_select_n_i(pin.async_write_select_n),
		.async_read_select_n_i(pin.async_read_select_n),
		.data_in_bus_i(din), .data_out_bus_o(dout), .data_out_oe_o(oe),
		.empty_flag_n_o(ef), .full_flag_n_o(ff), .almost_empty_flag_n_o(aef),
		.almost_full_flag_n_o(aff), .half_full_flag_n_o(hff));

	task automatic cmp_data(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		if (mismatches == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic logic [35:0] rnd();
		return {4'($urandom()), $urandom()};
	endfunction

	// Master reset with the configuration pins held steady
	task automatic mreset(input logic ft, input logic bm, input logic ow, input logic be,
		input logic asy_n);
		@(posedge clk_sys_i);
		pin.master_reset_n <= 1'b0;
		pin.serial_in <= ft;
		pin.bus_match_select <= bm;
		pin.output_width_select <= ow;
		pin.endian_select <= be;
		pin.async_write_select_n <= asy_n;
		pin.async_read_select_n <= asy_n;
		repeat (6) @(posedge clk_sys_i);
		pin.master_reset_n <= 1'b1;
		repeat (6) @(negedge clk_sys_i);
	endtask

	// Read edge whose result is noted for the watcher
	task automatic rdx(input logic en_n, input logic [35:0] d);
		exp_q.push_back(d);
		partner.rd(en_n);
	endtask

	task automatic idle_rd(input int n);
		repeat (n) partner.rd(1'b1);
	endtask

	// Each read result is matched against the oldest note
	always @(negedge rclk) begin
		if (exp_q.size() > 0) cmp_data(dout, exp_q.pop_front());
	end

	// Hang guard
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		int i, k, n, sz, pos;
		mismatches = 0;
		n_checks = 0;
		cyc = 0;
		pin = '0;
		pin.master_reset_n = 1'b1;
		pin.serial_load_enable_n = 1'b1;
		pin.offset_load_n = 1'b1;
		pin.async_write_select_n = 1'b1;
		pin.async_read_select_n = 1'b1;
		rst_b_i = 1'b0;
		void'($urandom(32'h58ba));
		repeat (4) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		// Standard timing, 36 bits both sides
		mreset(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		cmp_bit(ef, 1'b0);
		cmp_bit(ff, 1'b1);
		cmp_bit(aef, 1'b0);
		cmp_bit(aff & hff, 1'b1);
		cmp_data(dout, 36'h0);
		rdx(1'b0, 36'h0);
		for (i = 0; i < 3; i++) w[i] = rnd();
		partner.wr(1'b0, w[0]);
		partner.wr(1'b1, w[1]);
		partner.wr(1'b0, w[2]);
		idle_rd(2);
		cmp_bit(ef, 1'b1);
		rdx(1'b0, w[0]);
		rdx(1'b1, w[0]);
		rdx(1'b0, w[2]);
		// Fill to the brim, then one more that must bounce
		for (i = 0; i < 17; i++) begin
			w[i] = rnd();
			partner.wr(1'b0, w[i]);
		end
		cmp_bit(ff, 1'b0);
		cmp_bit(hff, 1'b0);
		cmp_bit(aff, 1'b0);
		idle_rd(2);
		cmp_bit(aef, 1'b1);
		rdx(1'b0, w[0]);
		repeat (2) partner.wr(1'b1, rnd());
		cmp_bit(ff, 1'b1);
		for (i = 1; i < 16; i++) rdx(1'b0, w[i]);
		rdx(1'b0, w[15]);
		cmp_bit(ef, 1'b0);
		cmp_bit(hff, 1'b1);
		// Offsets: defaults read back, then shifted in bit by bit
		@(posedge clk_sys_i);
		pin.offset_load_n <= 1'b0;
		rdx(1'b0, {32'h0, DEFAULT_OFFSET[4][3:0]});
		rdx(1'b0, {32'h0, DEFAULT_OFFSET[4][3:0]});
		k = $urandom();
		for (i = 7; i >= 0; i--) begin
			@(posedge clk_sys_i);
			pin.serial_load_enable_n <= 1'b0;
			pin.serial_in <= k[i];
			partner.wr(1'b1, rnd());
		end
		// Serial enable high: this edge must leave the offsets alone
		@(posedge clk_sys_i);
		pin.serial_load_enable_n <= 1'b1;
		pin.serial_in <= ~k[0];
		partner.wr(1'b1, rnd());
		rdx(1'b0, {32'h0, k[7:4]});
		rdx(1'b0, {32'h0, k[3:0]});
		// Parallel method: load held low through master reset
		mreset(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		rdx(1'b0, {32'h0, DEFAULT_OFFSET[0][3:0]});
		rdx(1'b0, {32'h0, DEFAULT_OFFSET[0][3:0]});
		w[0] = rnd();
		partner.wr(1'b0, w[0]);
		partner.wr(1'b0, ~w[0]);
		rdx(1'b0, {32'h0, w[0][3:0]});
		rdx(1'b0, {32'h0, ~w[0][3:0]});
		@(posedge clk_sys_i);
		pin.offset_load_n <= 1'b1;
		// Bus matching both ways, both byte orders
		for (k = 0; k < 8; k++) begin
			@(posedge clk_sys_i);
			pin.input_width_select <= k[2];
			mreset(1'b0, 1'b1, k[1], k[0], 1'b1);
			w[0] = rnd();
			n = k[1] ? 4 : 2;
			sz = k[1] ? 9 : 18;
			if (k[2]) begin
				// Narrow parts, upper bits left dirty on purpose
				for (i = 0; i < n; i++) begin
					pos = k[0] ? i : n - 1 - i;
					partner.wr(1'b0, w[0] >> (pos * sz));
				end
				idle_rd(2);
				rdx(1'b0, w[0]);
			end else begin
				partner.wr(1'b0, w[0]);
				idle_rd(2);
				for (i = 0; i < n; i++) begin
					pos = k[0] ? i : n - 1 - i;
					rdx(1'b0, (w[0] >> (pos * sz)) & ((36'h1 << sz) - 36'h1));
				end
			end
		end
		// Fall-through: first word shows by itself on the third edge
		mreset(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		cmp_bit(ef, 1'b1);
		cmp_bit(ff, 1'b0);
		w[0] = rnd();
		partner.wr(1'b0, w[0]);
		idle_rd(1);
		rdx(1'b1, 36'h0);
		rdx(1'b1, w[0]);
		cmp_bit(ef, 1'b0);
		rdx(1'b0, w[0]);
		cmp_bit(ef, 1'b1);
		// Strobe-driven ports, enables tied low
		mreset(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		w[0] = rnd();
		w[1] = rnd();
		partner.wr(1'b0, w[0]);
		partner.wr(1'b0, w[1]);
		repeat (20) @(posedge clk_sys_i);
		rdx(1'b0, w[0]);
		rdx(1'b0, w[1]);
		// Output drive follows the enable pin
		@(posedge clk_sys_i);
		pin.output_enable_n <= 1'b1;
		repeat (5) @(negedge clk_sys_i);
		cmp_bit(oe, 1'b0);
		pin.output_enable_n <= 1'b0;
		repeat (5) @(negedge clk_sys_i);
		cmp_bit(oe, 1'b1);
		end_of_test();
	end
endmodule

// >>> sim/fifo_port_partner.sv
`timescale 1ns/1ps
module fifo_port_partner (
	output logic write_clock_o,
	output logic read_clock_o,
	output logic write_enable_n_o,
	output logic read_enable_n_o,
	output logic [35:0] data_in_bus_o
);
	// Both link clocks stand still between transfers
	initial begin
		write_clock_o = 1'b0;
		read_clock_o = 1'b0;
		write_enable_n_o = 1'b1;
		read_enable_n_o = 1'b1;
		data_in_bus_o = 36'h0;
	end

	// One 64 ns write period; data scrambled once its hold has passed
	task automatic wr(input logic en_n, input logic [35:0] d);
		write_enable_n_o = en_n;
		data_in_bus_o = d;
		#8 write_clock_o = 1'b1;
		#32 write_clock_o = 1'b0;
		data_in_bus_o = ~d;
		#24;
	endtask

	// One 64 ns read period; read enable is set to the caller's level before the rising edge
	task automatic rd(input logic en_n);
		read_enable_n_o = en_n;
		#8 read_clock_o = 1'b1;
		#32 read_clock_o = 1'b0;
		#24;
	endtask
endmodule

// >>> src/fifo_port_core.sv
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fifo_port_core
	import fifo_port_pkg::*;
#(
	parameter int PTR_W = DEPTH_LOG2
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic write_clock_i,
	input wire logic read_clock_i,
	input wire logic master_reset_n_i,
	input wire logic write_enable_n_i,
	input wire logic read_enable_n_i,
	input wire logic serial_load_enable_n_i,
	input wire logic offset_load_n_i,
	input wire logic output_enable_n_i,
	input wire logic fallthrough_select_serial_in_i,
	input wire logic default_offset_select0_i,
	input wire logic default_offset_select1_i,
	input wire logic bus_match_select_i,
	input wire logic input_width_select_i,
	input wire logic output_width_select_i,
	input wire logic endian_select_i,
	input wire logic async_write_select_n_i,
	input wire logic async_read_select_n_i,
	input wire logic [35:0] data_in_bus_i,
	output logic [35:0] data_out_bus_o,
	output logic data_out_oe_o,
	output logic empty_flag_n_o,
	output logic full_flag_n_o,
	output logic almost_empty_flag_n_o,
	output logic almost_full_flag_n_o,
	output logic half_full_flag_n_o
);

	localparam int DEPTH = 1 << PTR_W;
	localparam logic [PTR_W:0] DEPTH_CNT = {1'b1, {PTR_W{1'b0}}};
	localparam logic [PTR_W:0] HALF_CNT = {2'b01, {(PTR_W-1){1'b0}}};

	typedef struct packed {
		pins_t sync1;
		pins_t sync2;
		logic write_clock_prev;
		logic read_clock_prev;
		cfg_t cfg;
		logic [PTR_W:0] wr_ptr;
		logic [PTR_W:0] rd_ptr;
		logic [PTR_W:0] wr_side_rd0;
		logic [PTR_W:0] wr_side_rd1;
		logic [PTR_W:0] rd_side_wr0;
		logic [PTR_W:0] rd_side_wr1;
		logic [35:0] in_word;
		logic [1:0] in_part;
		logic [35:0] out_word;
		logic [1:0] out_part;
		logic out_loaded;
		logic [PTR_W-1:0] empty_offset;
		logic [PTR_W-1:0] full_offset;
		logic par_wr_sel;
		logic par_rd_sel;
		logic [35:0] data_out;
		logic data_oe;
		logic empty_pin;
		logic full_pin;
		logic almost_empty_n;
		logic almost_full_n;
		logic half_full_n;
	} state_t;

	state_t s;
	state_t n;
	pins_t pins_now;
	pins_t p;
	logic [WORD_W-1:0] ram [DEPTH];
	logic ram_we;
	logic [35:0] ram_wdata;
	logic wr_edge;
	logic rd_edge;
	logic in_reset;
	logic full_blk;
	logic consume;
	logic ram_has;
	logic load_q;
	logic [35:0] word_tmp;
	logic [1:0] last_in;
	logic [1:0] last_out;
	logic [PTR_W:0] rd_seen;
	logic [PTR_W:0] wr_seen;
	logic [PTR_W:0] wcount;
	logic [PTR_W:0] rcount;

	// Raw pins gathered for the synchroniser
	assign pins_now = '{
		write_clock: write_clock_i,
		read_clock: read_clock_i,
		master_reset_n: master_reset_n_i,
		write_enable_n: write_enable_n_i,
		read_enable_n: read_enable_n_i,
		serial_load_enable_n: serial_load_enable_n_i,
		offset_load_n: offset_load_n_i,
		output_enable_n: output_enable_n_i,
		serial_in: fallthrough_select_serial_in_i,
		offset_select: {default_offset_select1_i, default_offset_select0_i},
		bus_match_select: bus_match_select_i,
		input_width_select: input_width_select_i,
		output_width_select: output_width_select_i,
		endian_select: endian_select_i,
		async_write_select_n: async_write_select_n_i,
		async_read_select_n: async_read_select_n_i,
		data_in_bus: data_in_bus_i
	};

	// Edges seen on the synchronised clocks or strobes
	assign p = s.sync2;
	assign wr_edge = p.write_clock & ~s.write_clock_prev;
	assign rd_edge = p.read_clock & ~s.read_clock_prev;
	assign in_reset = ~p.master_reset_n;
	assign last_in = width_last(s.cfg.in_width);
	assign last_out = width_last(s.cfg.out_width);

	// Next-state logic for the whole block
	always_comb begin
		n = s;
		ram_we = 1'b0;
		ram_wdata = '0;
		consume = 1'b0;
		ram_has = 1'b0;
		load_q = 1'b0;
		word_tmp = '0;
		rd_seen = '0;
		wr_seen = '0;
		wcount = '0;
		rcount = '0;
		full_blk = s.cfg.fall_through_mode ? s.full_pin : ~s.full_pin;
		n.sync1 = pins_now;
		n.sync2 = s.sync1;
		n.write_clock_prev = p.write_clock;
		n.read_clock_prev = p.read_clock;
		n.data_oe = ~p.output_enable_n;
		if (in_reset) begin
			// Catch configuration and clear the datapath
			n.cfg.fall_through_mode = p.serial_in;
			n.cfg.serial_prog = p.offset_load_n;
			n.cfg.little_endian = p.endian_select;
			n.cfg.async_write = ~p.async_write_select_n;
			n.cfg.async_read = ~p.async_read_select_n;
			if (!p.bus_match_select) begin
				n.cfg.in_width = WIDTH_X36;
				n.cfg.out_width = WIDTH_X36;
			end else if (!p.input_width_select) begin
				n.cfg.in_width = WIDTH_X36;
				n.cfg.out_width = p.output_width_select ? WIDTH_X9 : WIDTH_X18;
			end else begin
				n.cfg.in_width = p.output_width_select ? WIDTH_X9 : WIDTH_X18;
				n.cfg.out_width = WIDTH_X36;
			end
			n.empty_offset = PTR_W'(DEFAULT_OFFSET[{p.offset_load_n, p.offset_select}]);
			n.full_offset = PTR_W'(DEFAULT_OFFSET[{p.offset_load_n, p.offset_select}]);
			n.wr_ptr = '0;
			n.rd_ptr = '0;
			n.wr_side_rd0 = '0;
			n.wr_side_rd1 = '0;
			n.rd_side_wr0 = '0;
			n.rd_side_wr1 = '0;
			n.in_word = '0;
			n.in_part = '0;
			n.out_word = '0;
			n.out_part = '0;
			n.out_loaded = 1'b0;
			n.par_wr_sel = 1'b0;
			n.par_rd_sel = 1'b0;
			n.data_out = RESET_DATA_OUT;
			n.empty_pin = p.serial_in;
			n.full_pin = ~p.serial_in;
			n.almost_empty_n = RESET_ALMOST_EMPTY_N;
			n.almost_full_n = RESET_ALMOST_FULL_N;
			n.half_full_n = RESET_HALF_FULL_N;
		end else begin
			// Write port: offsets or data on each write edge
			if (wr_edge) begin
				n.wr_side_rd0 = s.rd_ptr;
				n.wr_side_rd1 = s.wr_side_rd0;
				if (!p.offset_load_n) begin
					if (s.cfg.serial_prog) begin
						if (!p.serial_load_enable_n) begin
							{n.empty_offset, n.full_offset} =
								{s.empty_offset[PTR_W-2:0], s.full_offset, p.serial_in};
						end
					end else if (!p.write_enable_n) begin
						if (s.par_wr_sel) begin
							n.full_offset = p.data_in_bus[PTR_W-1:0];
						end else begin
							n.empty_offset = p.data_in_bus[PTR_W-1:0];
						end
						n.par_wr_sel = ~s.par_wr_sel;
					end
				end else if ((!p.write_enable_n || s.cfg.async_write) && !full_blk) begin
					word_tmp = place(s.in_word, p.data_in_bus,
						part_pos(s.in_part, s.cfg.in_width, s.cfg.little_endian),
						s.cfg.in_width);
					if (s.in_part == last_in) begin
						ram_we = 1'b1;
						ram_wdata = word_tmp;
						n.wr_ptr = s.wr_ptr + 1'b1;
						n.in_word = '0;
						n.in_part = '0;
					end else begin
						n.in_word = word_tmp;
						n.in_part = s.in_part + 2'h1;
					end
				end
			end
			// Full flags follow the delayed read pointer, or the live one with async writes; half-full uses the live pointers
			rd_seen = s.cfg.async_write ? s.rd_ptr : n.wr_side_rd1;
			wcount = n.wr_ptr - rd_seen;
			if (wr_edge || s.cfg.async_write) begin
				n.full_pin = s.cfg.fall_through_mode ? (wcount == DEPTH_CNT)
					: (wcount != DEPTH_CNT);
			end
			if (wr_edge) begin
				n.almost_full_n = ~(wcount >= DEPTH_CNT - {1'b0, s.full_offset});
				if ((n.wr_ptr - s.rd_ptr) > HALF_CNT) begin
					n.half_full_n = 1'b0;
				end
			end
			// Read port: offsets, fall-through or standard fetch
			if (rd_edge) begin
				n.rd_side_wr0 = s.wr_ptr;
				n.rd_side_wr1 = s.rd_side_wr0;
				ram_has = s.rd_side_wr1 != s.rd_ptr;
				if (!p.offset_load_n) begin
					if (!p.read_enable_n) begin
						n.data_out = 36'({s.par_rd_sel ? s.full_offset : s.empty_offset});
						n.par_rd_sel = ~s.par_rd_sel;
					end
				end else if (s.cfg.fall_through_mode) begin
					consume = !p.read_enable_n && !s.empty_pin;
					if (consume && s.out_loaded && s.out_part != last_out) begin
						n.out_part = s.out_part + 2'h1;
						load_q = 1'b1;
					end else if (consume || !s.out_loaded) begin
						if (ram_has) begin
							n.out_word = ram[s.rd_ptr[PTR_W-1:0]];
							n.rd_ptr = s.rd_ptr + 1'b1;
							n.out_part = '0;
							n.out_loaded = 1'b1;
							n.empty_pin = 1'b0;
							load_q = 1'b1;
						end else if (consume) begin
							n.out_loaded = 1'b0;
							n.empty_pin = 1'b1;
						end
					end
				end else if ((!p.read_enable_n || s.cfg.async_read) && s.empty_pin) begin
					if (s.out_loaded && s.out_part != last_out) begin
						n.out_part = s.out_part + 2'h1;
					end else begin
						n.out_word = ram[s.rd_ptr[PTR_W-1:0]];
						n.rd_ptr = s.rd_ptr + 1'b1;
						n.out_part = '0;
						n.out_loaded = 1'b1;
					end
					load_q = 1'b1;
				end
			end
			// Output register changes here only on a fetch; offset reads set it above
			if (load_q) begin
				n.data_out = pick(n.out_word,
					part_pos(n.out_part, s.cfg.out_width, s.cfg.little_endian),
					s.cfg.out_width);
			end
			// Standard empty flag and almost-empty follow the delayed write pointer, or the live one with async reads; half-full uses the live pointers
			wr_seen = s.cfg.async_read ? s.wr_ptr : n.rd_side_wr1;
			rcount = wr_seen - n.rd_ptr;
			if (!s.cfg.fall_through_mode && (rd_edge || s.cfg.async_read)) begin
				n.empty_pin = (n.out_loaded && n.out_part != last_out)
					|| (wr_seen != n.rd_ptr);
			end
			if (rd_edge) begin
				n.almost_empty_n = ~(rcount <= {1'b0, s.empty_offset});
				if ((n.wr_ptr - n.rd_ptr) <= HALF_CNT) begin
					n.half_full_n = 1'b1;
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Storage array, no reset
	always_ff @(posedge clk_sys_i) begin
		if (ram_we) begin
			ram[s.wr_ptr[PTR_W-1:0]] <= ram_wdata;
		end
	end

	// Outputs straight from state
	assign data_out_bus_o = s.data_out;
	assign data_out_oe_o = s.data_oe;
	assign empty_flag_n_o = s.empty_pin;
	assign full_flag_n_o = s.full_pin;
	assign almost_empty_flag_n_o = s.almost_empty_n;
	assign almost_full_flag_n_o = s.almost_full_n;
	assign half_full_flag_n_o = s.half_full_n;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b_i);

	// Steps of a final fall-through read
	sequence last_read_s;
		rd_edge && !in_reset && s.cfg.fall_through_mode && p.offset_load_n
			&& !p.read_enable_n && !s.empty_pin && s.out_part == last_out
			&& s.rd_side_wr1 == s.rd_ptr;
	endsequence

	sequence stale_shown_s;
		s.empty_pin && $stable(s.data_out);
	endsequence

	mode_latch_a: assert property (in_reset |=> s.cfg.fall_through_mode == $past(p.serial_in))
		else $error("timing mode not latched from pin");

	reset_values_a: assert property (rst_b_i && in_reset |=> s.wr_ptr == '0 && s.rd_ptr == '0
		&& s.data_out == 36'h0 && !s.almost_empty_n && s.almost_full_n && s.half_full_n)
		else $error("master reset values wrong");

	write_store_a: assert property (wr_edge && !in_reset && p.offset_load_n
		&& !p.write_enable_n && !full_blk && s.in_part == last_in
		|=> s.wr_ptr == $past(s.wr_ptr) + 1'b1)
		else $error("enabled write not stored");

	write_idle_a: assert property (wr_edge && !in_reset && p.write_enable_n
		&& !s.cfg.async_write |=> s.wr_ptr == $past(s.wr_ptr) && s.in_part == $past(s.in_part))
		else $error("write with enable high");

	full_block_a: assert property (!in_reset && full_blk |=> s.wr_ptr == $past(s.wr_ptr))
		else $error("write while full");

	write_flags_a: assert property (!wr_edge && !in_reset && !s.cfg.async_write
		|=> $stable(s.almost_full_n) && $stable(s.full_pin))
		else $error("write flag moved without edge");

	read_flags_a: assert property (!rd_edge && !in_reset |=> $stable(s.almost_empty_n))
		else $error("read flag moved without edge");

	read_hold_a: assert property (rd_edge && !in_reset && !s.cfg.fall_through_mode
		&& !s.cfg.async_read && p.read_enable_n |=> $stable(s.data_out) && $stable(s.rd_ptr))
		else $error("output changed with read enable high");

	output_drive_a: assert property (rst_b_i
		|=> data_out_oe_o == !$past(p.output_enable_n))
		else $error("output enable not followed");

	last_word_a: assert property (last_read_s |=> stale_shown_s)
		else $error("ready flag or data wrong after last read");

endmodule
